// ==== rtl/rrctop.sv ====
`timescale 1ns/1ps
// Purpose: rotate-right-through-carry execution slice of an 8-bit core
// Assumes: register file read is combinational, write happens on the next edge
// Notes: accumulator, carry and write port all registered
module rrctop
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_I,
    // instruction
    input wire logic INSTR_VALID_I,
    input wire logic [rrcpkg::RRC_IW-1:0] INSTR_I,
    // register file read port
    output logic [rrcpkg::RRC_AW-1:0] RF_RADDR_O,
    input wire logic [rrcpkg::RRC_DW-1:0] RF_RDATA_I,
    // register file write port
    output logic RF_WE_O,
    output logic [rrcpkg::RRC_AW-1:0] RF_WADDR_O,
    output logic [rrcpkg::RRC_DW-1:0] RF_WDATA_O,
    // accumulator and status
    output logic [rrcpkg::RRC_DW-1:0] ACC_O,
    output logic CARRY_O,
    output logic DONE_O
);
    import rrcpkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode
    rrc_dec_t dec;
    logic fire;
    logic [RRC_DW-1:0] rot_res;
    logic rot_carry;

    always_comb
    begin
        dec = rrc_decode(INSTR_I);
        fire = INSTR_VALID_I && dec.valid;
    end

    assign RF_RADDR_O = dec.sel;

    rrcrot u_rot (
        .val_i(RF_RDATA_I),
        .carry_i(CARRY_O),
        .res_o(rot_res),
        .carry_o(rot_carry)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [RRC_DW-1:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic done_q, done_d;
    rrc_wr_t wr_q, wr_d;

    always_comb
    begin
        acc_d = acc_q;
        carry_d = carry_q;
        done_d = fire;
        wr_d = '0;
        if (fire)
        begin
            carry_d = rot_carry;
            if (dec.dest == RRC_DEST_ACC)
            begin
                acc_d = rot_res;
            end
            else
            begin
                wr_d.we = 1'b1;
                wr_d.addr = dec.sel;
                wr_d.data = rot_res;
            end
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RESET_I)
        begin
            acc_q <= RRC_ACC_RST;
            carry_q <= RRC_CARRY_RST;
            done_q <= 1'b0;
            wr_q <= '0;
        end
        else
        begin
            acc_q <= acc_d;
            carry_q <= carry_d;
            done_q <= done_d;
            wr_q <= wr_d;
        end
    end

    assign ACC_O = acc_q;
    assign CARRY_O = carry_q;
    assign DONE_O = done_q;
    assign RF_WE_O = wr_q.we;
    assign RF_WADDR_O = wr_q.addr;
    assign RF_WDATA_O = wr_q.data;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_acc_op;
        INSTR_VALID_I && INSTR_I[RRC_OP_HI:RRC_OP_LO] == RRC_OP_PATTERN
            && INSTR_I[RRC_DEST_BIT] == RRC_DEST_ACC;
    endsequence

    sequence s_file_op;
        INSTR_VALID_I && INSTR_I[RRC_OP_HI:RRC_OP_LO] == RRC_OP_PATTERN
            && INSTR_I[RRC_DEST_BIT] == RRC_DEST_FILE;
    endsequence

    property p_acc_result;
        @(posedge CLK_I) disable iff (RESET_I)
        s_acc_op |=> ACC_O == {$past(CARRY_O), $past(RF_RDATA_I[7:1])};
    endproperty
    a_acc_result: assert property (p_acc_result) else $error("acc result wrong");

    property p_acc_no_write;
        @(posedge CLK_I) disable iff (RESET_I)
        s_acc_op |=> !RF_WE_O;
    endproperty
    a_acc_no_write: assert property (p_acc_no_write) else $error("file written on acc op");

    property p_file_result;
        @(posedge CLK_I) disable iff (RESET_I)
        s_file_op |=> RF_WE_O && RF_WADDR_O == $past(INSTR_I[4:0])
            && RF_WDATA_O == {$past(CARRY_O), $past(RF_RDATA_I[7:1])};
    endproperty
    a_file_result: assert property (p_file_result) else $error("file write wrong");

    property p_file_acc_hold;
        @(posedge CLK_I) disable iff (RESET_I)
        s_file_op |=> $stable(ACC_O);
    endproperty
    a_file_acc_hold: assert property (p_file_acc_hold) else $error("acc changed");

    property p_carry_out;
        @(posedge CLK_I) disable iff (RESET_I)
        (s_acc_op or s_file_op) |=> CARRY_O == $past(RF_RDATA_I[0]);
    endproperty
    a_carry_out: assert property (p_carry_out) else $error("carry wrong");

    property p_one_cycle;
        @(posedge CLK_I) disable iff (RESET_I)
        (s_acc_op or s_file_op) |=> DONE_O;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("not single cycle");

    property p_idle;
        @(posedge CLK_I) disable iff (RESET_I)
        !(INSTR_VALID_I && INSTR_I[RRC_OP_HI:RRC_OP_LO] == RRC_OP_PATTERN) |=>
            !RF_WE_O && !DONE_O && $stable(CARRY_O) && $stable(ACC_O);
    endproperty
    a_idle: assert property (p_idle) else $error("change without op");

    property p_reset_values;
        @(posedge CLK_I)
        RESET_I |=> ACC_O == RRC_ACC_RST && CARRY_O == RRC_CARRY_RST && !DONE_O
            && !RF_WE_O && RF_WADDR_O == '0 && RF_WDATA_O == '0;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_read_addr;
        @(posedge CLK_I) disable iff (RESET_I)
        RF_RADDR_O == INSTR_I[RRC_AW-1:0];
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("read address wrong");

    property p_acc_bus_clear;
        @(posedge CLK_I) disable iff (RESET_I)
        s_acc_op |=> RF_WADDR_O == '0 && RF_WDATA_O == '0;
    endproperty
    a_acc_bus_clear: assert property (p_acc_bus_clear) else $error("write bus busy");

    property p_file_same_reg;
        @(posedge CLK_I) disable iff (RESET_I)
        s_file_op |=> RF_WADDR_O == $past(RF_RADDR_O);
    endproperty
    a_file_same_reg: assert property (p_file_same_reg) else $error("wrong register");

    property p_wr_with_done;
        @(posedge CLK_I) disable iff (RESET_I)
        RF_WE_O |-> DONE_O;
    endproperty
    a_wr_with_done: assert property (p_wr_with_done) else $error("write without done");

    property p_done_only_op;
        @(posedge CLK_I) disable iff (RESET_I)
        DONE_O |-> $past(INSTR_VALID_I)
            && $past(INSTR_I[RRC_OP_HI:RRC_OP_LO]) == RRC_OP_PATTERN;
    endproperty
    a_done_only_op: assert property (p_done_only_op) else $error("done without op");

    property p_ignored_op;
        @(posedge CLK_I) disable iff (RESET_I)
        INSTR_VALID_I && INSTR_I[RRC_OP_HI:RRC_OP_LO] != RRC_OP_PATTERN |=>
            !DONE_O && !RF_WE_O && $stable(ACC_O) && $stable(CARRY_O);
    endproperty
    a_ignored_op: assert property (p_ignored_op) else $error("other op acted");

    property p_no_valid;
        @(posedge CLK_I) disable iff (RESET_I)
        !INSTR_VALID_I |=> !DONE_O && !RF_WE_O && $stable(ACC_O) && $stable(CARRY_O);
    endproperty
    a_no_valid: assert property (p_no_valid) else $error("acted without valid");

    // carry handed from one op to the next
    sequence s_any_op;
        INSTR_VALID_I && INSTR_I[RRC_OP_HI:RRC_OP_LO] == RRC_OP_PATTERN;
    endsequence

    sequence s_chain_acc;
        s_any_op ##1 s_acc_op;
    endsequence

    sequence s_chain_file;
        s_any_op ##1 s_file_op;
    endsequence

    property p_acc_chain;
        @(posedge CLK_I) disable iff (RESET_I)
        s_chain_acc |=> ACC_O[RRC_DW-1] == $past(RF_RDATA_I[0], 2);
    endproperty
    a_acc_chain: assert property (p_acc_chain) else $error("carry not chained to acc");

    property p_file_chain;
        @(posedge CLK_I) disable iff (RESET_I)
        s_chain_file |=> RF_WDATA_O[RRC_DW-1] == $past(RF_RDATA_I[0], 2);
    endproperty
    a_file_chain: assert property (p_file_chain) else $error("carry not chained");
endmodule

// ==== rtl/rrcpkg.sv ====
// Purpose: constants and types for the rotate-right-through-carry datapath slice
// Assumes: 12-bit instruction words, 8-bit data, 32 file registers
// Notes: one instruction per cycle; no software-visible registers
package rrcpkg;
    localparam int RRC_IW = 12;
    localparam int RRC_DW = 8;
    localparam int RRC_AW = 5;
    localparam logic [5:0] RRC_OP_PATTERN = 6'h0C;
    localparam int RRC_OP_HI = 11;
    localparam int RRC_OP_LO = 6;
    localparam int RRC_DEST_BIT = 5;
    localparam logic RRC_DEST_ACC = 1'b0;
    localparam logic RRC_DEST_FILE = 1'b1;
    localparam logic [7:0] RRC_ACC_RST = 8'h00;
    localparam logic RRC_CARRY_RST = 1'b0;

    typedef struct packed {
        logic valid;
        logic [RRC_AW-1:0] sel;
        logic dest;
    } rrc_dec_t;

    typedef struct packed {
        logic we;
        logic [RRC_AW-1:0] addr;
        logic [RRC_DW-1:0] data;
    } rrc_wr_t;

    function automatic rrc_dec_t rrc_decode(input logic [RRC_IW-1:0] iw);
        rrc_dec_t d;
        d.valid = (iw[RRC_OP_HI:RRC_OP_LO] == RRC_OP_PATTERN);
        d.sel = iw[RRC_AW-1:0];
        d.dest = iw[RRC_DEST_BIT];
        return d;
    endfunction
endpackage

// ==== rtl/rrcrot.sv ====
`timescale 1ns/1ps
// Purpose: combinational rotate right through carry
// Assumes: 8-bit operand
// Notes: pure logic, no state
module rrcrot
(
    // operand
    input wire logic [rrcpkg::RRC_DW-1:0] val_i,
    input wire logic carry_i,
    // result
    output logic [rrcpkg::RRC_DW-1:0] res_o,
    output logic carry_o
);
    import rrcpkg::*;

    always_comb
    begin
        res_o = {carry_i, val_i[RRC_DW-1:1]};
        carry_o = val_i[0];
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: random self-checking bench for the rotate-through-carry slice
// Assumes: combinational register file read, one note per cycle
// Notes: inputs driven at falling edge, results checked after rising edge
`timescale 1ns/1ps
module testbench;
    import rrcpkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld = 1'b0;
    logic [11:0] ins = 12'h000;
    logic [7:0] rd = 8'h00;
    logic [4:0] raddr, waddr;
    logic [7:0] wdata, acc, res;
    logic we, carry, done;
    logic [23:0] q[$];
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] r = 32'hA579465E;
    logic [7:0] acc_m = 8'h00;
    logic c_m = 1'b0;

    rrctop i_dut (.CLK_I(clk), .RESET_I(rst), .INSTR_VALID_I(vld), .INSTR_I(ins),
        .RF_RADDR_O(raddr), .RF_RDATA_I(rd), .RF_WE_O(we), .RF_WADDR_O(waddr),
        .RF_WDATA_O(wdata), .ACC_O(acc), .CARRY_O(carry), .DONE_O(done));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [23:0] e, input logic [23:0] s);
        checks_done++;
        if (e !== s)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
            n_mismatch++;
        end
    endtask

    task automatic results;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 clk = ~clk;
    end

    initial
    begin
        #10000;
        n_mismatch++;
        results();
    end

    // driver: stimulus plus expected outputs after the next edge
    initial
    begin
        repeat (5) @(negedge clk);
        for (int i = 0; i < 400; i++)
        begin
            @(negedge clk);
            r = lfsr(r);
            rst = (i == 200);
            vld = (i != 0) && (i != 201) && (r[13:12] != 2'h0);
            ins = r[14] ? r[11:0] : {RRC_OP_PATTERN, r[5:0]};
            rd = r[23:16];
            if (rst)
            begin
                acc_m = 8'h00;
                c_m = 1'b0;
                q.push_back(24'h000000);
            end
            else if (vld && ins[11:6] == 6'h0C)
            begin
                res = {c_m, rd[7:1]};
                c_m = rd[0];
                if (ins[5])
                    q.push_back({2'h3, ins[4:0], res, acc_m, c_m});
                else
                begin
                    acc_m = res;
                    q.push_back({2'h2, 5'h00, 8'h00, acc_m, c_m});
                end
            end
            else
                q.push_back({2'h0, 5'h00, 8'h00, acc_m, c_m});
            #1 check("read address", {19'h00000, ins[4:0]}, {19'h00000, raddr});
        end
        @(negedge clk);
        vld = 1'b0;
        repeat (2) @(negedge clk);
        results();
    end

    // watcher: oldest note against outputs just after every rising edge while notes are queued
    always @(posedge clk)
    begin
        if (q.size() > 0)
        begin
            #1 check("result", q[0], {done, we, waddr, wdata, acc, carry});
            void'(q.pop_front());
        end
    end
endmodule
